// File: design/clock_fanout_output_control.sv
// Output enable, bypass and reference monitor control of the clock fan-out buffer
`timescale 1ns/100ps
`default_nettype none
module clock_fanout_output_control (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       referenceClockIn,
   input  wire logic       feedbackClockIn,
   input  wire logic       loopSupply,
   input  wire logic       serialBusClock,
   input  wire logic       serialBusDataIn,
   output logic            serialBusDataOut,
   output logic            serialBusDataOe,
   output logic [5:0]      trueClockOut,
   output logic [5:0]      trueClockOe,
   output logic [5:0]      complementClockOut,
   output logic [5:0]      complementClockOe,
   output logic            feedbackClockOut,
   output logic            feedbackClockOe,
   output logic            loopActive,
   output logic            loopLocked,
   output logic            referenceSlow
);
   typedef enum logic [1:0] {BUS_IDLE, BUS_SHIFT, BUS_ACK, BUS_IGNORE} bus_state_t;
   typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_COUNT, PH_DATA} bus_phase_t;

   function automatic logic [7:0] satInc(input logic [7:0] v);
      satInc = (v == 8'hFF) ? v : v + 8'h01;
   endfunction

   logic [4:0] syncIn;
   logic       refS;
   logic       fbS;
   logic       supplyS;
   logic       sclS;
   logic       sdaS;

   sync_two_stage #(.W(5)) pinSync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .asyncIn ({referenceClockIn, feedbackClockIn, loopSupply,
                 serialBusClock, serialBusDataIn}),
      .syncOut (syncIn)
   );

   assign refS    = syncIn[4];
   assign fbS     = syncIn[3];
   assign supplyS = syncIn[2];
   assign sclS    = syncIn[1];
   assign sdaS    = syncIn[0];

   // Serial bus slave state
   bus_state_t busState_r;
   bus_state_t busState_nxt;
   bus_phase_t phase_r;
   bus_phase_t phase_nxt;
   logic [3:0] bitCnt_r;
   logic [3:0] bitCnt_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [1:0] dataIdx_r;
   logic [1:0] dataIdx_nxt;
   logic       ackOe_r;
   logic       ackOe_nxt;
   logic [5:0] reqEn_r;
   logic [5:0] reqEn_nxt;
   logic       sclPrev_r;
   logic       sdaPrev_r;
   logic       sclRise;
   logic       sclFall;
   logic       busStart;
   logic       busStop;

   assign sclRise  = sclS & ~sclPrev_r;
   assign sclFall  = ~sclS & sclPrev_r;
   assign busStart = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
   assign busStop  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

   always_comb begin
      busState_nxt = busState_r;
      phase_nxt    = phase_r;
      bitCnt_nxt   = bitCnt_r;
      shift_nxt    = shift_r;
      dataIdx_nxt  = dataIdx_r;
      ackOe_nxt    = ackOe_r;
      reqEn_nxt    = reqEn_r;
      if (busStop) begin
         busState_nxt = BUS_IDLE;
         ackOe_nxt    = 1'b0;
      end else if (busStart) begin
         busState_nxt = BUS_SHIFT;
         phase_nxt    = PH_ADDR;
         bitCnt_nxt   = 4'h0;
         dataIdx_nxt  = 2'h0;
         ackOe_nxt    = 1'b0;
      end else begin
         unique case (busState_r)
            BUS_IDLE, BUS_IGNORE: begin
            end
            BUS_SHIFT: begin
               if (sclRise && bitCnt_r != clock_fanout_pkg::BITS_PER_BYTE) begin
                  shift_nxt  = {shift_r[6:0], sdaS};
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (sclFall && bitCnt_r == clock_fanout_pkg::BITS_PER_BYTE) begin
                  // Only a write to our address is acknowledged
                  if (phase_r == PH_ADDR &&
                      (shift_r[7:1] != clock_fanout_pkg::DEV_ADDR || shift_r[0])) begin
                     busState_nxt = BUS_IGNORE;
                  end else begin
                     ackOe_nxt    = 1'b1;
                     busState_nxt = BUS_ACK;
                     // Command and count bytes are acknowledged but carry no data
                     if (phase_r == PH_DATA && dataIdx_r == 2'h0) begin
                        // Reserved bits are dropped here
                        reqEn_nxt[0] = shift_r[clock_fanout_pkg::B0_PAIR0];
                        reqEn_nxt[1] = shift_r[clock_fanout_pkg::B0_PAIR1];
                        reqEn_nxt[2] = shift_r[clock_fanout_pkg::B0_PAIR2];
                        reqEn_nxt[5] = shift_r[clock_fanout_pkg::B0_PAIR5];
                        reqEn_nxt[4] = shift_r[clock_fanout_pkg::B0_PAIR4];
                     end else if (phase_r == PH_DATA && dataIdx_r == 2'h1) begin
                        reqEn_nxt[3] = shift_r[clock_fanout_pkg::B1_PAIR3];
                     end
                     if (phase_r == PH_DATA && dataIdx_r != 2'h2) begin
                        dataIdx_nxt = dataIdx_r + 2'h1;
                     end
                  end
               end
            end
            BUS_ACK: begin
               if (sclFall) begin
                  ackOe_nxt    = 1'b0;
                  bitCnt_nxt   = 4'h0;
                  busState_nxt = BUS_SHIFT;
                  unique case (phase_r)
                     PH_ADDR:  phase_nxt = PH_CMD;
                     PH_CMD:   phase_nxt = PH_COUNT;
                     PH_COUNT: phase_nxt = PH_DATA;
                     PH_DATA:  phase_nxt = PH_DATA;
                  endcase
               end
            end
         endcase
      end
   end

   // Enables come back to their power-up value through resetn or a data write with every enable bit set
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         busState_r <= BUS_IDLE;
         phase_r    <= PH_ADDR;
         bitCnt_r   <= 4'h0;
         shift_r    <= 8'h00;
         dataIdx_r  <= 2'h0;
         ackOe_r    <= 1'b0;
         reqEn_r    <= clock_fanout_pkg::ENABLE_RESET;
         sclPrev_r  <= 1'b1;
         sdaPrev_r  <= 1'b1;
      end else begin
         busState_r <= busState_nxt;
         phase_r    <= phase_nxt;
         bitCnt_r   <= bitCnt_nxt;
         shift_r    <= shift_nxt;
         dataIdx_r  <= dataIdx_nxt;
         ackOe_r    <= ackOe_nxt;
         reqEn_r    <= reqEn_nxt;
         sclPrev_r  <= sclS;
         sdaPrev_r  <= sdaS;
      end
   end

   // Reference monitor and loop status
   logic            refPrev_r;
   logic            fbPrev_r;
   logic [7:0]      period_r;
   logic [7:0]      period_nxt;
   logic [7:0]      sinceRef_r;
   logic [7:0]      sinceRef_nxt;
   logic            slow_r;
   logic            slow_nxt;
   logic            locked_r;
   logic            locked_nxt;
   logic            refRise;
   logic            refFall;
   logic            fbRise;
   logic            floatAll;

   assign refRise  = refS & ~refPrev_r;
   assign refFall  = ~refS & refPrev_r;
   assign fbRise   = fbS & ~fbPrev_r;
   assign floatAll = supplyS & slow_r;

   always_comb begin
      period_nxt   = refRise ? 8'h00 : satInc(period_r);
      sinceRef_nxt = refRise ? 8'h00 : satInc(sinceRef_r);
      // Gaps between reference edges longer than the limit mean too slow
      slow_nxt     = period_r >= 8'(clock_fanout_pkg::REF_MAX_PERIOD_CYC);
      locked_nxt   = locked_r;
      // Feedback edge soon after the reference edge means zero delay achieved
      if (!supplyS || slow_r) begin
         locked_nxt = 1'b0;
      end else if (fbRise) begin
         locked_nxt = sinceRef_r <= 8'(clock_fanout_pkg::LOCK_WINDOW_CYC);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         refPrev_r  <= 1'b0;
         fbPrev_r   <= 1'b0;
         period_r   <= 8'hFF;  // Counts as slow until a first reference edge
         sinceRef_r <= 8'h00;
         slow_r     <= 1'b1;
         locked_r   <= 1'b0;
      end else begin
         refPrev_r  <= refS;
         fbPrev_r   <= fbS;
         period_r   <= period_nxt;
         sinceRef_r <= sinceRef_nxt;
         slow_r     <= slow_nxt;
         locked_r   <= locked_nxt;
      end
   end

   // Output stage; a new enable lands one cycle after the falling output edge
   logic [5:0] apEn_r;
   logic [5:0] apEn_nxt;
   logic [5:0] trueOut_r;
   logic [5:0] trueOut_nxt;
   logic [5:0] pairOe_r;
   logic [5:0] pairOe_nxt;
   logic       feedback_clock_out_r;
   logic       feedback_clock_out_nxt;
   logic       fbOe_r;
   logic       fbOe_nxt;
   logic       loopOn_r;
   logic       loopOn_nxt;
   logic [5:0] compOut_r;
   logic [5:0] compOut_nxt;

   always_comb begin
      // Switching as the low phase starts keeps pulses whole; while floatAll is set the enables load at any point
      apEn_nxt    = (refFall || floatAll) ? reqEn_r : apEn_r;
      // Same level on every pair, whether the loop runs or is bypassed
      trueOut_nxt = {clock_fanout_pkg::PAIRS{refS}};
      compOut_nxt = ~{clock_fanout_pkg::PAIRS{refS}};
      pairOe_nxt  = apEn_r & ~{clock_fanout_pkg::PAIRS{floatAll}};
      feedback_clock_out_nxt   = refS;
      // No enable bit reaches the feedback driver
      fbOe_nxt    = ~floatAll;
      loopOn_nxt  = supplyS & ~slow_r;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         apEn_r    <= clock_fanout_pkg::ENABLE_RESET;
         trueOut_r <= 6'h00;
         compOut_r <= 6'h3F;
         pairOe_r  <= 6'h00;
         feedback_clock_out_r   <= 1'b0;
         fbOe_r    <= 1'b0;
         loopOn_r  <= 1'b0;
      end else begin
         apEn_r    <= apEn_nxt;
         trueOut_r <= trueOut_nxt;
         compOut_r <= compOut_nxt;
         pairOe_r  <= pairOe_nxt;
         feedback_clock_out_r   <= feedback_clock_out_nxt;
         fbOe_r    <= fbOe_nxt;
         loopOn_r  <= loopOn_nxt;
      end
   end

   // Acknowledge pulls the open-drain data line low
   assign serialBusDataOut   = 1'b0;
   assign serialBusDataOe    = ackOe_r;
   assign trueClockOut       = trueOut_r;
   assign complementClockOut = compOut_r;
   assign trueClockOe        = pairOe_r;
   assign complementClockOe  = pairOe_r;
   assign feedbackClockOut   = feedback_clock_out_r;
   assign feedbackClockOe    = fbOe_r;
   assign loopActive         = loopOn_r;
   assign loopLocked         = locked_r;
   assign referenceSlow      = slow_r;
endmodule
`default_nettype wire

// File: design/sync_two_stage.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync_two_stage #(
   parameter int unsigned W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] asyncIn,
   output var  logic [W-1:0] syncOut
);
   logic [W-1:0] meta_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r  <= '0;
         syncOut <= '0;
      end else begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule
`default_nettype wire

// File: dv/clock_fanout_output_control_props.sv
// Port checker for the clock fan-out control block
`timescale 1ns/100ps
`default_nettype none
module clock_fanout_output_control_props (
   input wire logic       sys_clk,
   input wire logic       resetn,
   input wire logic       referenceClockIn,
   input wire logic       feedbackClockIn,
   input wire logic       loopSupply,
   input wire logic       serialBusClock,
   input wire logic       serialBusDataIn,
   input wire logic       serialBusDataOut,
   input wire logic       serialBusDataOe,
   input wire logic [5:0] trueClockOut,
   input wire logic [5:0] trueClockOe,
   input wire logic [5:0] complementClockOut,
   input wire logic [5:0] complementClockOe,
   input wire logic       feedbackClockOut,
   input wire logic       feedbackClockOe,
   input wire logic       loopActive,
   input wire logic       loopLocked,
   input wire logic       referenceSlow
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_comp_inverse: assert property (
      complementClockOut == ~trueClockOut) else $error("complement not inverse of true");
   a_pair_oe_match: assert property (
      complementClockOe == trueClockOe) else $error("pair halves differ in enable");
   // Five cycles after reset let the synchronisers fill before following is judged
   a_true_follows: assert property (
      resetn[*5] |-> ((trueClockOut ^ {6{$past(referenceClockIn, 3)}}) & trueClockOe) == 6'h00)
      else $error("true output does not follow reference");
   a_fb_follows: assert property (
      resetn[*5] ##0 feedbackClockOe |-> feedbackClockOut == $past(referenceClockIn, 3))
      else $error("feedback does not follow reference");
   a_bypass_drives: assert property (
      (!loopSupply)[*5] |-> feedbackClockOe && !loopActive) else $error("bypass not driving");
   a_slow_floats: assert property (
      loopSupply[*5] ##0 referenceSlow[*3] |-> trueClockOe == 6'h00 && !feedbackClockOe)
      else $error("slow reference left outputs driven");
   a_fb_oe_cause: assert property (
      !feedbackClockOe |-> $past(referenceSlow)) else $error("feedback floated without cause");
   a_no_runt: assert property (
      !referenceSlow && !$past(referenceSlow) && !$past(referenceSlow, 2)
      |-> ((trueClockOe ^ $past(trueClockOe)) & trueClockOut) == 6'h00)
      else $error("enable changed while output high");
   a_ack_hold: assert property (
      $rose(serialBusDataOe) |-> serialBusDataOe[*8]) else $error("acknowledge too short");
   a_ack_ends: assert property (
      $rose(serialBusDataOe) |-> ##[8:300] !serialBusDataOe) else $error("acknowledge stuck");
   a_active_cause: assert property (
      loopActive |-> !$past(referenceSlow)) else $error("loop active on slow reference");
   c_ack: cover property ($rose(serialBusDataOe));
   c_ref_back: cover property ($fell(referenceSlow));
   c_pair_off: cover property ($fell(trueClockOe[0]));
endmodule
bind clock_fanout_output_control clock_fanout_output_control_props u_props (
   .sys_clk(sys_clk), .resetn(resetn), .referenceClockIn(referenceClockIn),
   .feedbackClockIn(feedbackClockIn), .loopSupply(loopSupply),
   .serialBusClock(serialBusClock), .serialBusDataIn(serialBusDataIn),
   .serialBusDataOut(serialBusDataOut), .serialBusDataOe(serialBusDataOe),
   .trueClockOut(trueClockOut), .trueClockOe(trueClockOe),
   .complementClockOut(complementClockOut), .complementClockOe(complementClockOe),
   .feedbackClockOut(feedbackClockOut), .feedbackClockOe(feedbackClockOe),
   .loopActive(loopActive), .loopLocked(loopLocked), .referenceSlow(referenceSlow));
`default_nettype wire

// File: dv/clock_fanout_output_control_test.sv
// Testbench for the clock fan-out control block
`timescale 1ns/100ps
`default_nettype none
module clock_fanout_output_control_test;
   logic       sys_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       loopSupply = 1'b1;
   logic       refRun = 1'b1;
   logic [3:0] refCnt = 4'h0;
   logic       sdoOut, sdoOe, feedback_clock_out, fbOe, loopActive, loopLocked, referenceSlow;
   logic       sclOut, sdaLow;
   logic [5:0] tOut, tOe, cOut, cOe;
   wire logic  sdaLevel = ~(sdaLow | (sdoOe & ~sdoOut));
   int         bad_count = 0;
   int         num_checks = 0;
   int         acks;
   logic [7:0] b0Tab [6] = '{8'h4D, 8'h8D, 8'hC5, 8'hCD, 8'hCC, 8'hC9};
   logic [7:0] b1Tab [6] = '{8'h40, 8'h40, 8'h40, 8'hBF, 8'h40, 8'h40};
   logic [7:0] addrW;
   always #25 sys_clk = ~sys_clk;
   // Stand-in reference, period 16 cycles, well under the slow limit
   always @(posedge sys_clk) begin
      #1;
      if (refRun) begin
         refCnt = refCnt + 4'h1;
      end
   end
   clock_fanout_output_control dut (
      .sys_clk(sys_clk), .resetn(resetn), .referenceClockIn(refCnt[3]),
      .feedbackClockIn(feedback_clock_out), .loopSupply(loopSupply), .serialBusClock(sclOut),
      .serialBusDataIn(sdaLevel), .serialBusDataOut(sdoOut), .serialBusDataOe(sdoOe),
      .trueClockOut(tOut), .trueClockOe(tOe), .complementClockOut(cOut),
      .complementClockOe(cOe), .feedbackClockOut(feedback_clock_out), .feedbackClockOe(fbOe),
      .loopActive(loopActive), .loopLocked(loopLocked), .referenceSlow(referenceSlow));
   serial_host_model host (
      .sys_clk(sys_clk), .sdaLevel(sdaLevel), .sclOut(sclOut), .sdaLow(sdaLow));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic frame(input logic [7:0] a, b0, b1, input int exAcks);
      host.write_frame(a, b0, b1, acks);
      repeat (40) @(posedge sys_clk);
      #1;
      chk(8'(acks), 8'(exAcks));
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      addrW = {clock_fanout_pkg::DEV_ADDR, 1'b0};
      settle(5);
      resetn = 1'b1;
      settle(100);
      chk(tOe, 6'h3F);
      chk(cOe, 6'h3F);
      chk(loopActive, 1'b1);
      chk(loopLocked, 1'b1);
      for (int p = 0; p < 6; p++) begin
         frame(addrW, b0Tab[p], b1Tab[p], 5);
         chk(tOe, {2'b00, ~(6'h01 << p)});
      end
      frame(addrW, 8'h00, 8'h00, 5);
      chk(tOe, 6'h00);
      chk(fbOe, 1'b1);
      frame(addrW ^ 8'h02, 8'hCD, 8'h40, 0);
      frame(addrW | 8'h01, 8'hCD, 8'h40, 0);
      chk(tOe, 6'h00);
      frame(addrW, 8'hCD, 8'h40, 5);
      chk(tOe, 6'h3F);
      refRun = 1'b0;
      settle(100);
      chk({referenceSlow, loopActive, fbOe}, 8'h04);
      chk(tOe, 6'h00);
      chk(loopLocked, 1'b0);
      loopSupply = 1'b0;
      settle(20);
      chk({fbOe, loopActive}, 8'h02);
      chk(tOe, 6'h3F);
      refRun = 1'b1;
      settle(60);
      loopSupply = 1'b1;
      frame(addrW, 8'h00, 8'h00, 5);
      chk(tOe, 6'h00);
      resetn = 1'b0;
      settle(5);
      resetn = 1'b1;
      settle(100);
      chk(tOe, 6'h3F);
      test_done();
   end
   // Whole sequence needs about 10000 cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire

// File: dv/serial_host_model.sv
// Serial bus host that writes the enable bytes
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
   input  wire logic sys_clk,
   input  wire logic sdaLevel,
   output var  logic sclOut,
   output var  logic sdaLow
);
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   // Six cycles a phase keeps every bus phase above the four-cycle minimum
   task automatic phase();
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   task automatic send(input logic [7:0] b, inout int acks);
      for (int i = 8; i >= 0; i--) begin
         sdaLow = (i > 0) ? ~b[i-1] : 1'b0; // MSB first, then release
         phase();
         sclOut = 1'b1;
         phase();
         if (i == 0 && sdaLevel === 1'b0) begin
            acks++;
         end
         sclOut = 1'b0;
         phase();
      end
   endtask
   task automatic write_frame(input logic [7:0] addr, b0, b1, output int acks);
      acks = 0;
      sdaLow = 1'b1;
      phase();
      sclOut = 1'b0;
      send(addr, acks);
      send(8'h00, acks); // Command code before byte count
      send(8'h02, acks);
      send(b0, acks);
      send(b1, acks);
      sdaLow = 1'b1;
      phase();
      sclOut = 1'b1;
      phase();
      sdaLow = 1'b0;
      phase();
   endtask
endmodule
`default_nettype wire

// File: include/clock_fanout_pkg.sv
// Constants shared by the clock fan-out control logic
package clock_fanout_pkg;
   localparam int unsigned CLK_FREQ_KHZ      = 20000;
   // Minimum reference frequency while the loop is powered
   localparam int unsigned REF_MIN_FREQ_KHZ  = 20000;
   // The sampled reference is a stand-in running this many times slower
   localparam int unsigned REF_SCALE         = 64;
   localparam int unsigned REF_MAX_PERIOD_CYC =
      (CLK_FREQ_KHZ * REF_SCALE) / REF_MIN_FREQ_KHZ;
   // Feedback edge must follow the reference edge within this many cycles
   localparam int unsigned LOCK_WINDOW_CYC   = 2;
   localparam int unsigned CNT_W             = 8;
   localparam int unsigned PAIRS             = 6;
   // Bus address, arbitrary value
   localparam logic [6:0]  DEV_ADDR          = 7'h5A;
   localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;
   // Enable bit positions in the first enable byte
   localparam int unsigned B0_PAIR0 = 7;
   localparam int unsigned B0_PAIR1 = 6;
   localparam int unsigned B0_PAIR2 = 3;
   localparam int unsigned B0_PAIR5 = 2;
   localparam int unsigned B0_PAIR4 = 0;
   // Enable bit position in the second enable byte
   localparam int unsigned B1_PAIR3 = 6;
   // Power-up values
   localparam logic [7:0]  FIRST_BYTE_RESET  = 8'hFF;
   localparam logic [7:0]  SECOND_BYTE_RESET = 8'hC0;
   localparam logic [5:0]  ENABLE_RESET      = 6'h3F;
endpackage
